// *** hw/id_run_pkg.sv ***
package id_run_pkg;
    // Record field widths
    localparam int IDENT_W    = 5;
    localparam int XLOC_W     = 11;
    localparam int DUR_W      = 11;
    localparam int PAIR_W     = 2 * IDENT_W;
    localparam int ENTRY_W    = PAIR_W + DUR_W;
    localparam int FIFO_DEPTH = 64;
    // Field positions inside a pair FIFO entry
    localparam int ENT_DUR_LSB  = 0;
    localparam int ENT_LOW_LSB  = DUR_W;
    localparam int ENT_HIGH_LSB = DUR_W + IDENT_W;
    // Duration of the split entry
    localparam logic [DUR_W-1:0] SPLIT_DUR = 11'h001;
    // Output pipeline stages after the pair register
    localparam int OUT_STAGES = 2;
    // Free entries kept back for the up-to-two writes of a record in flight
    localparam int FILL_HEADROOM = 2;
    // Conversion sequencer
    typedef enum logic [1:0] {CONV_IDLE, CONV_RUN, CONV_SPLIT} conv_state_type;
endpackage

// *** hw/display_id_run_expander.sv ***
`timescale 1ns/1ps
module display_id_run_expander
#(
    parameter int DEPTH = id_run_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                             i_mclk,
    input  wire logic                             i_rst,
    // Control and timing channels
    input  wire logic                             i_gen_enable,
    input  wire logic                             i_end_of_field_channel,
    input  wire logic                             i_visible_line_channel,
    // Record load from the master controller
    input  wire logic                             i_rec_load,
    input  wire logic [id_run_pkg::XLOC_W-1:0]    i_rec_x_loc,
    input  wire logic [id_run_pkg::IDENT_W-1:0]   i_rec_ident,
    // Requests to the master controller
    output logic                                  o_fill_req,
    output logic                                  o_eof_req,
    // Identifier pair stream
    output logic [id_run_pkg::IDENT_W-1:0]        o_pair_low_ident,
    output logic [id_run_pkg::IDENT_W-1:0]        o_pair_high_ident
);
    import id_run_pkg::*;

    localparam int AW = $clog2(DEPTH);

    // Pointers wrap by power of two, and filling needs room beyond the headroom
    if (DEPTH <= FILL_HEADROOM || (1 << AW) != DEPTH) begin : g_depth_check
        $error("DEPTH must be a power of two above the fill headroom");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Storage and state
    logic [ENTRY_W-1:0]   mem_q [DEPTH];
    logic [AW-1:0]        wr_ptr_q;
    logic [AW-1:0]        rd_ptr_q;
    logic [AW:0]          depth_q;
    logic [XLOC_W-1:0]    cur_x_loc_q;
    logic [XLOC_W-1:0]    next_x_loc_q;
    logic [IDENT_W-1:0]   cur_ident_q;
    logic [IDENT_W-1:0]   next_ident_q;
    conv_state_type       conv_q;
    logic [DUR_W-1:0]     dur_cnt_q;
    logic                 run_valid_q;
    logic [PAIR_W-1:0]    pair_q;
    logic [PAIR_W-1:0]    pipe_q [OUT_STAGES];
    logic                 eof_q;

    logic                 full;
    logic                 empty;
    logic                 want_wr;
    logic                 do_wr;
    logic                 do_rd;
    logic [ENTRY_W-1:0]   wr_entry;
    logic [DUR_W-1:0]     diff;

    // Half-pixel index of an X location: drop pixel bit 0
    function automatic logic [DUR_W-1:0] half_loc(input logic [XLOC_W-1:0] x);
        half_loc = {1'b0, x[XLOC_W-1:1]};
    endfunction

    // Pack slots with the less significant pixel low
    function automatic logic [ENTRY_W-1:0] pack(input logic [IDENT_W-1:0] lo,
                                                input logic [IDENT_W-1:0] hi,
                                                input logic [DUR_W-1:0]   d);
        pack = {hi, lo, d};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Conversion datapath
    always_comb begin
        diff = half_loc(next_x_loc_q) - half_loc(cur_x_loc_q);
        wr_entry = '0;
        want_wr = 1'b0;
        case (conv_q)
            CONV_RUN: begin
                wr_entry = pack(cur_ident_q, cur_ident_q, diff);
                want_wr = (diff != '0);
            end
            CONV_SPLIT: begin
                wr_entry = pack(cur_ident_q, next_ident_q, SPLIT_DUR);
                want_wr = next_x_loc_q[0];
            end
            default: begin
                wr_entry = '0;
                want_wr = 1'b0;
            end
        endcase
    end

    assign full  = (depth_q == (AW+1)'(DEPTH));
    assign empty = (depth_q == '0);
    assign do_wr = want_wr && !full && !i_end_of_field_channel;
    // Next entry is taken when no run is active or the run expires
    assign do_rd = !empty && !i_end_of_field_channel &&
                   (!run_valid_q || dur_cnt_q == '0);

    ////////////////////////////////////////////////////////////////////////////
    // Record registers and conversion sequencer; relies on the controller
    // loading only while fill is requested and not during conversion
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cur_x_loc_q  <= '0;
            next_x_loc_q <= '0;
            cur_ident_q  <= '0;
            next_ident_q <= '0;
            conv_q       <= CONV_IDLE;
        end else if (i_rec_load) begin
            cur_x_loc_q  <= next_x_loc_q;
            cur_ident_q  <= next_ident_q;
            next_x_loc_q <= i_rec_x_loc;
            next_ident_q <= i_rec_ident;
            conv_q       <= CONV_RUN;
        end else begin
            case (conv_q)
                CONV_RUN:   conv_q <= CONV_SPLIT;
                CONV_SPLIT: begin
                    conv_q <= CONV_IDLE;
                    if (next_x_loc_q[0]) begin
                        next_x_loc_q <= next_x_loc_q + 1'b1;
                    end
                end
                default:    conv_q <= CONV_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // FIFO storage and pointers
    always_ff @(posedge i_mclk) begin
        if (do_wr) begin
            mem_q[wr_ptr_q] <= wr_entry;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst || i_end_of_field_channel) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            depth_q  <= '0;
        end else begin
            if (do_wr) wr_ptr_q <= wr_ptr_q + 1'b1;
            if (do_rd) rd_ptr_q <= rd_ptr_q + 1'b1;
            case ({do_wr, do_rd})
                2'b10:   depth_q <= depth_q + 1'b1;
                2'b01:   depth_q <= depth_q - 1'b1;
                default: depth_q <= depth_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Duration counter and pair register
    always_ff @(posedge i_mclk) begin
        if (i_rst || i_end_of_field_channel) begin
            dur_cnt_q   <= '0;
            run_valid_q <= 1'b0;
            pair_q      <= '0;
        end else if (do_rd) begin
            // Stored duration counts cycles; one is spent in this load cycle
            dur_cnt_q   <= mem_q[rd_ptr_q][ENT_DUR_LSB +: DUR_W] - 1'b1;
            pair_q      <= mem_q[rd_ptr_q][ENT_LOW_LSB +: PAIR_W];
            run_valid_q <= 1'b1;
        end else if (run_valid_q && dur_cnt_q != '0) begin
            dur_cnt_q <= dur_cnt_q - 1'b1;
        end else begin
            run_valid_q <= 1'b0; // Underrun: hold last pair
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output pipeline, gated by the visible-line channel
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            for (int i = 0; i < OUT_STAGES; i++) begin
                pipe_q[i] <= '0;
            end
        end else begin
            pipe_q[0] <= pair_q;
            for (int i = 1; i < OUT_STAGES; i++) begin
                pipe_q[i] <= pipe_q[i-1];
            end
        end
    end

    // Only the final gating flop sets the one-cycle channel-to-pin delay
    always_ff @(posedge i_mclk) begin
        if (i_rst || !i_visible_line_channel) begin
            o_pair_low_ident  <= '0;
            o_pair_high_ident <= '0;
        end else begin
            o_pair_low_ident  <= pipe_q[OUT_STAGES-1][0 +: IDENT_W];
            o_pair_high_ident <= pipe_q[OUT_STAGES-1][IDENT_W +: IDENT_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Requests to the controller
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_fill_req <= 1'b0;
            o_eof_req  <= 1'b0;
            eof_q      <= 1'b0;
        end else begin
            // Leave headroom for the up-to-two writes of a record in flight
            o_fill_req <= i_gen_enable && !i_end_of_field_channel &&
                          (depth_q < (AW+1)'(DEPTH - FILL_HEADROOM)) &&
                          (conv_q == CONV_IDLE) && !i_rec_load;
            eof_q      <= i_end_of_field_channel;
            o_eof_req  <= i_end_of_field_channel && !eof_q;
        end
    end

endmodule

// *** dv/id_run_chk.sv ***
`timescale 1ns/1ps
module id_run_chk
    import id_run_pkg::*;
#(parameter int DEPTH = FIFO_DEPTH) (
    // Control and channels
    input wire logic               i_mclk,
    input wire logic               i_rst,
    input wire logic               i_gen_enable,
    input wire logic               i_end_of_field_channel,
    input wire logic               i_visible_line_channel,
    // Record load
    input wire logic               i_rec_load,
    input wire logic [XLOC_W-1:0]  i_rec_x_loc,
    input wire logic [IDENT_W-1:0] i_rec_ident,
    // Outputs
    input wire logic               o_fill_req,
    input wire logic               o_eof_req,
    input wire logic [IDENT_W-1:0] o_pair_low_ident,
    input wire logic [IDENT_W-1:0] o_pair_high_ident
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // Channel edge as two steps
    sequence eof_rise_s; !i_end_of_field_channel ##1 i_end_of_field_channel; endsequence
    eof_pulse_a: assert property (eof_rise_s |=> o_eof_req) else $error("eof request missing");
    eof_single_a: assert property (o_eof_req |=> !o_eof_req) else $error("eof request too long");
    eof_cause_a: assert property (o_eof_req |-> $past(i_end_of_field_channel) &&
        !$past(i_end_of_field_channel, 2)) else $error("eof request without edge");
    vis_gate_a: assert property (!$past(i_visible_line_channel) |->
        o_pair_low_ident == '0 && o_pair_high_ident == '0) else $error("ident outside visible");
    fill_en_a: assert property (!i_gen_enable |=> !o_fill_req) else $error("fill while disabled");
    fill_eof_a: assert property (i_end_of_field_channel |=> !o_fill_req) else $error("fill in eof");
    fill_load_a: assert property (i_rec_load |=> !o_fill_req) else $error("fill during load");
    fill_wake_a: assert property ($fell(i_rst) |-> !o_fill_req && !o_eof_req) else $error("busy after reset");
endmodule
bind display_id_run_expander id_run_chk #(.DEPTH(DEPTH)) u_chk (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_gen_enable(i_gen_enable), .i_end_of_field_channel(i_end_of_field_channel),
    .i_visible_line_channel(i_visible_line_channel), .i_rec_load(i_rec_load), .i_rec_x_loc(i_rec_x_loc),
    .i_rec_ident(i_rec_ident), .o_fill_req(o_fill_req), .o_eof_req(o_eof_req),
    .o_pair_low_ident(o_pair_low_ident), .o_pair_high_ident(o_pair_high_ident));

// *** dv/id_rec_source_model.sv ***
`timescale 1ns/1ps
module id_rec_source_model
    import id_run_pkg::*;
(
    // Clock and reset
    input wire logic          i_mclk,
    input wire logic          i_rst,
    // Fill request and pacing
    input wire logic          i_fill_req,
    input wire logic [3:0]    i_gap,
    // Record load towards the block
    output logic              o_rec_load,
    output logic [XLOC_W-1:0] o_rec_x_loc,
    output logic [IDENT_W-1:0] o_rec_ident
);
    logic [XLOC_W-1:0] x_tbl [9] = '{11'h000, 11'h078, 11'h07C, 11'h07F, 11'h080, 11'h08C, 11'h08D, 11'h0B4, 11'h0C8};
    int idx = 0;
    int wait_n = 0;
    initial begin
        o_rec_load = 1'b0;
        o_rec_x_loc = '0;
        o_rec_ident = '0;
    end
    // Load next record when room; data lines toggle while idle so stale values never match
    always @(negedge i_mclk) begin
        if (i_rst) begin
            idx = 0;
            wait_n = 0;
            o_rec_load = 1'b0;
        end else if (i_fill_req && !o_rec_load && wait_n >= int'(i_gap) && idx < 9) begin
            o_rec_load = 1'b1;
            o_rec_x_loc = x_tbl[idx];
            o_rec_ident = IDENT_W'(idx + 1);
            idx++;
            wait_n = 0;
        end else begin
            o_rec_load = 1'b0;
            o_rec_x_loc = ~o_rec_x_loc;
            o_rec_ident = ~o_rec_ident;
            wait_n += int'(i_fill_req);
        end
    end
endmodule

// *** dv/display_id_run_expander_tb.sv ***
`timescale 1ns/1ps
module display_id_run_expander_tb;
    import id_run_pkg::*;
    logic               i_mclk = 1'b0;
    logic               i_rst = 1'b1;
    logic               gen_en = 1'b0;
    logic               eof_ch = 1'b0;
    logic               vis_ch = 1'b0;
    logic [3:0]         gap = 4'h0;
    logic               rec_load, fill_req, eof_req;
    logic [XLOC_W-1:0]  rec_x;
    logic [IDENT_W-1:0] rec_id, lo, hi;
    int                 bad_count = 0;
    int                 checks_done = 0;
    int                 cyc = 0;
    ////////////////////////////////////////
    initial begin
        forever #25 i_mclk = ~i_mclk;
    end
    display_id_run_expander #(.DEPTH(FIFO_DEPTH)) u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_gen_enable(gen_en),
        .i_end_of_field_channel(eof_ch), .i_visible_line_channel(vis_ch), .i_rec_load(rec_load),
        .i_rec_x_loc(rec_x), .i_rec_ident(rec_id), .o_fill_req(fill_req), .o_eof_req(eof_req),
        .o_pair_low_ident(lo), .o_pair_high_ident(hi));
    id_rec_source_model u_src (.i_mclk(i_mclk), .i_rst(i_rst), .i_fill_req(fill_req), .i_gap(gap),
        .o_rec_load(rec_load), .o_rec_x_loc(rec_x), .o_rec_ident(rec_id));
    ////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // Pair runs seen while visible, against the example line worked by hand
    task automatic test_stream(input logic [3:0] g);
        logic [9:0] ep [8] = '{10'h021, 10'h042, 10'h063, 10'h064, 10'h0A5, 10'h0C7, 10'h0E7, 10'h108};
        int el [8] = '{60, 2, 1, 1, 6, 1, 19, 10};
        logic [9:0] cur;
        int n, k;
        cur = '0;
        n = 0;
        k = 0;
        gap = g;
        i_rst = 1'b1;
        repeat (5) @(negedge i_mclk);
        i_rst = 1'b0;
        gen_en = 1'b1;
        vis_ch = 1'b1;
        repeat (220) begin
            @(negedge i_mclk);
            if ({lo, hi} !== cur) begin
                if (cur !== '0 && k < 7) begin
                    cmp(32'(cur), 32'(ep[k]), "pair");
                    cmp(32'(n), 32'(el[k]), "run length");
                    k++;
                end
                cur = {lo, hi};
                n = 0;
            end
            n++;
        end
        cmp(32'(k), 32'h7, "run count");
        cmp(32'(cur), 32'(ep[7]), "last pair");
        cmp(32'(n >= el[7]), 32'h1, "last run");
        $display("test stream gap %0d done", g);
    endtask
    // Blanking gates the pair one cycle later
    task automatic test_vis();
        vis_ch = 1'b0;
        @(negedge i_mclk);
        cmp(32'({lo, hi}), 32'h0, "blanked");
        vis_ch = 1'b1;
        @(negedge i_mclk);
        cmp(32'({lo, hi}), 32'h108, "restored");
        $display("test vis done");
    endtask
    // End of field pulses once and holds off filling
    task automatic test_eof();
        int seen;
        seen = 0;
        eof_ch = 1'b1;
        repeat (6) begin
            @(negedge i_mclk);
            seen += int'(eof_req === 1'b1);
        end
        cmp(32'(seen), 32'h1, "eof pulses");
        cmp(32'(fill_req), 32'h0, "fill in eof");
        cmp(32'({lo, hi}), 32'h0, "flushed");
        eof_ch = 1'b0;
        gen_en = 1'b0;
        repeat (3) @(negedge i_mclk);
        cmp(32'(fill_req), 32'h0, "fill off");
        gen_en = 1'b1;
        repeat (3) @(negedge i_mclk);
        cmp(32'(fill_req), 32'h1, "fill on");
        $display("test eof done");
    endtask
    ////////////////////////////////////////
    // Cut a hang short
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            wrap_up();
        end
    end
    initial begin
        test_stream(4'h0);
        test_vis();
        test_stream(4'h6);
        test_eof();
        wrap_up();
    end
endmodule
